/* design/hrs_sync.sv */
/*
  two flip-flop synchroniser for a level coming from a pin.
  assumes clk and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module hrs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= '0;
      dout      <= '0;
    end else begin
      stage1_ff <= din;
      dout      <= stage1_ff;
    end
  end
endmodule

/* design/hrs_timer.sv */
/*
  down counter: load sets a count, done pulses once when it reaches zero.
  assumes clk and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module hrs_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         stop,
  output logic              done,
  output logic              busy
);
  logic [W-1:0] cnt_ff;
  logic         run_ff;
  wire          hitZero = run_ff && (cnt_ff == '0);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (load) begin
      cnt_ff <= value;
      run_ff <= 1'b1;
    end else if (stop || hitZero) begin
      run_ff <= 1'b0;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign done = hitZero && !load && !stop;
  assign busy = run_ff;
endmodule

/* design/hub_reset_sequencer.sv */
/*
  hub reset sequencer: hardware reset handling, mode-dependent bring-up to attach,
  and the response to a bus reset from the upstream host.
  assumes a 40 MHz clk, rst_n already qualified by the power-on circuit, strap and
  upstream-reset inputs from pins, and load/request strobes from logic on clk.
*/
//
// Function
// - strap mode: non-strapped configuration takes internal default values
// - hardware reset and upstream bus reset are handled as distinct events
// - during hardware reset ports disabled, port_power_enable low
// - during hardware reset transceivers off, differential pairs high impedance
// - hardware reset aborts every transaction at once, nothing kept
// - hardware reset returns internal registers to defaults, mostly zero
// - oscillator and PLL halted while hardware reset is asserted
// - operational at most 500 us after reset release
// - eeprom mode: start reading configuration as soon as operational
// - strap mode: outputs inactive within 2 us after reset
// - strap mode: signal attach within 100 ms
// - eeprom mode: finish read and apply within 99.5 ms before attach
// - smbus mode: attach within 100 ms after code load finishes
// - in service every host request completes within 5 ms
// - upstream bus reset is never forwarded downstream
// - bus reset clears device address and configuration
// - bus reset drops both downstream port power enables
// - bus reset flushes translator buffers and resumes from suspend
// - smbus mode waits without limit for code load before attach
`timescale 1ns/1ps
module hub_reset_sequencer
  import hrs_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = hrs_pkg::RECOVER_CYC,
  parameter int unsigned ATTACH_CYCLES  = hrs_pkg::ATTACH_CYC,
  parameter int unsigned EE_LOAD_CYCLES = hrs_pkg::EE_LOAD_CYC,
  parameter int unsigned REQUEST_CYCLES = hrs_pkg::REQUEST_CYC,
  parameter int unsigned NPORT          = hrs_pkg::PORT_N
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [1:0]                 cfgSelPin,
  input  wire logic [NPORT-1:0]           strapNonRemovPin,
  input  wire logic                       upstreamBusResetPin,
  input  wire logic                       eeLoadDone,
  input  wire logic                       eeLoadError,
  input  wire logic                       smbLoadDone,
  input  wire logic [hrs_pkg::ADDR_W-1:0] setAddrValue,
  input  wire logic                       setAddrStrobe,
  input  wire logic                       setConfigStrobe,
  input  wire logic                       suspendReq,
  input  wire logic                       requestStart,
  input  wire logic                       requestDone,
  input  wire logic [NPORT-1:0]           portPowerReq,
  output logic                            oscEnable,
  output logic                            pllEnable,
  output logic                            phyEnable,
  output logic                            dpDmOutEn,
  output logic [NPORT-1:0]                port_power_enable,
  output logic [NPORT-1:0]                portEnable,
  output logic                            outputsActive,
  output logic                            operational,
  output logic                            eeLoadStart,
  output logic                            smbLoadEnable,
  output logic                            usbAttach,
  output logic                            configApply,
  output logic [NPORT-1:0]                nonRemovable,
  output logic [hrs_pkg::ADDR_W-1:0]      deviceAddr,
  output logic                            configured,
  output logic                            suspended,
  output logic                            ttFlush,
  output logic                            downstreamReset,
  output logic                            requestTimeout,
  output logic                            configFail
);
  import hrs_pkg::*;

  // reset release through two flip-flops
  logic rstSync1_ff;
  logic rstSync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_ff <= 1'b0;
      rstSync_ff  <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync_ff  <= rstSync1_ff;
    end
  end

  wire rstN = rstSync_ff;

  // clock sources run only outside hardware reset
  assign oscEnable = rst_n;
  assign pllEnable = rst_n;

  // pin inputs
  logic [1:0]       cfgSelSync;
  logic [NPORT-1:0] strapSync;
  logic             busRstSync;

  hrs_sync #(.W(2)) u_sync_sel (
    .clk  (clk),
    .rstN (rstN),
    .din  (cfgSelPin),
    .dout (cfgSelSync)
  );

  hrs_sync #(.W(NPORT)) u_sync_strap (
    .clk  (clk),
    .rstN (rstN),
    .din  (strapNonRemovPin),
    .dout (strapSync)
  );

  hrs_sync #(.W(1)) u_sync_busrst (
    .clk  (clk),
    .rstN (rstN),
    .din  (upstreamBusResetPin),
    .dout (busRstSync)
  );

  // bus reset edge and state
  logic busRstPrev_ff;
  wire  busRstRise = busRstSync && !busRstPrev_ff;

  // sequencer state
  hrs_state_e       state_ff;
  hrs_state_e       nxt_state;
  hrs_mode_e        mode_ff;
  logic [NPORT-1:0] nonRemov_ff;

  // timer control
  logic             tmrLoad;
  logic [CNT_W-1:0] tmrValue;
  logic             tmrDone;
  logic             tmrBusy;

  hrs_timer #(.W(CNT_W)) u_seq_timer (
    .clk   (clk),
    .rstN  (rstN),
    .load  (tmrLoad),
    .value (tmrValue),
    .stop  (1'b0),
    .done  (tmrDone),
    .busy  (tmrBusy)
  );

  // request watchdog
  logic reqTmrDone;
  logic reqTmrBusy;
  wire  inService = (state_ff == HRS_ST_RUN);
  wire  reqLoad   = inService && requestStart;

  hrs_timer #(.W(CNT_W)) u_req_timer (
    .clk   (clk),
    .rstN  (rstN),
    .load  (reqLoad),
    .value (CNT_W'(REQUEST_CYCLES - 1)),
    .stop  (requestDone || busRstRise),
    .done  (reqTmrDone),
    .busy  (reqTmrBusy)
  );

  // mode decode; straps are followed through recovery and frozen when the timer ends,
  // since the synchronised copy only settles one cycle after the timer starts
  wire       sampleMode = (state_ff == HRS_ST_RECOVER) && tmrBusy && !tmrDone;
  hrs_mode_e selMode;
  assign selMode = hrs_mode_e'(cfgSelSync);

  wire modeStrap  = (mode_ff == HRS_MODE_STRAP) || (mode_ff == HRS_MODE_RSVD);
  wire modeEeprom = (mode_ff == HRS_MODE_EEPROM);
  wire modeSmbus  = (mode_ff == HRS_MODE_SMBUS);

  always_comb begin
    nxt_state = state_ff;
    tmrLoad   = 1'b0;
    tmrValue  = '0;
    case (state_ff)
      HRS_ST_RECOVER: begin
        if (!tmrBusy) begin
          tmrLoad  = 1'b1;
          tmrValue = CNT_W'(RECOVER_CYCLES - 1);
        end
        if (tmrDone) begin
          nxt_state = modeStrap ? HRS_ST_INACT : HRS_ST_LOAD;
        end
      end
      HRS_ST_INACT: begin
        nxt_state = HRS_ST_APPLY;
        tmrLoad   = 1'b1;
        tmrValue  = CNT_W'(ATTACH_CYCLES - 1);
      end
      HRS_ST_LOAD: begin
        if (modeEeprom) begin
          if (!tmrBusy && !tmrDone) begin
            tmrLoad  = 1'b1;
            tmrValue = CNT_W'(EE_LOAD_CYCLES - 1);
          end
          if (eeLoadDone) begin
            nxt_state = HRS_ST_APPLY;
          end else if (eeLoadError || tmrDone) begin
            nxt_state = HRS_ST_FAIL;
          end
        end else if (smbLoadDone) begin
          nxt_state = HRS_ST_APPLY;
        end
      end
      HRS_ST_APPLY: begin
        nxt_state = HRS_ST_ATTACH;
      end
      HRS_ST_ATTACH: begin
        nxt_state = HRS_ST_RUN;
      end
      HRS_ST_RUN: begin
        nxt_state = HRS_ST_RUN;
      end
      HRS_ST_FAIL: begin
        nxt_state = HRS_ST_APPLY; // defaults are applied, then attach
      end
      default: begin
        nxt_state = HRS_ST_RECOVER;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_ff      <= HRS_ST_RECOVER;
      mode_ff       <= HRS_MODE_STRAP;
      nonRemov_ff   <= '0;
      busRstPrev_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      busRstPrev_ff <= busRstSync;
      if (sampleMode) begin
        mode_ff      <= selMode;
        nonRemov_ff  <= strapSync;
      end
    end
  end

  // outputs that follow the sequencer
  logic active_ff;
  logic attach_ff;
  logic apply_ff;
  logic eeStart_ff;
  logic fail_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      active_ff  <= 1'b0;
      attach_ff  <= 1'b0;
      apply_ff   <= 1'b0;
      eeStart_ff <= 1'b0;
      fail_ff    <= 1'b0;
    end else begin
      active_ff  <= (state_ff != HRS_ST_RECOVER) || tmrDone;
      apply_ff   <= (state_ff == HRS_ST_APPLY);
      eeStart_ff <= (state_ff == HRS_ST_RECOVER) && tmrDone && modeEeprom;
      if (state_ff == HRS_ST_ATTACH) begin
        attach_ff <= 1'b1;
      end
      if (state_ff == HRS_ST_FAIL) begin
        fail_ff <= 1'b1;
      end
    end
  end

  assign outputsActive = active_ff;
  assign operational   = active_ff;
  assign eeLoadStart   = eeStart_ff;
  assign smbLoadEnable = active_ff && modeSmbus && !attach_ff;
  assign usbAttach     = attach_ff;
  assign configApply   = apply_ff;
  assign configFail    = fail_ff;
  assign nonRemovable  = modeStrap ? nonRemov_ff : '0;

  // device state touched by the upstream bus reset
  logic [ADDR_W-1:0] addr_ff;
  logic              configured_ff;
  logic              suspended_ff;
  logic              flush_ff;
  logic [NPORT-1:0]  portPwr_ff;
  logic              reqTo_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      addr_ff       <= ADDR_RESET;
      configured_ff <= 1'b0;
      suspended_ff  <= 1'b0;
      flush_ff      <= 1'b0;
      portPwr_ff    <= '0;
      reqTo_ff      <= 1'b0;
    end else begin
      flush_ff <= busRstRise;
      if (busRstRise) begin
        addr_ff       <= ADDR_RESET;
        configured_ff <= 1'b0;
        suspended_ff  <= 1'b0;
        portPwr_ff    <= '0;
        reqTo_ff      <= 1'b0;
      end else if (inService) begin
        if (setAddrStrobe) begin
          addr_ff <= setAddrValue;
        end
        if (setConfigStrobe) begin
          configured_ff <= 1'b1;
        end
        suspended_ff <= suspendReq;
        portPwr_ff   <= configured_ff ? portPowerReq : '0;
        if (reqTmrDone) begin
          reqTo_ff <= 1'b1;
        end else if (requestStart) begin
          reqTo_ff <= 1'b0;
        end
      end
    end
  end

  // rstN is low during hardware reset, so every flop below shows its idle value
  assign deviceAddr        = addr_ff;
  assign configured        = configured_ff;
  assign suspended         = suspended_ff;
  assign ttFlush           = flush_ff;
  assign downstreamReset   = 1'b0;
  assign requestTimeout    = reqTo_ff;
  assign port_power_enable = portPwr_ff;
  assign portEnable        = configured_ff ? portPwr_ff : '0;
  assign phyEnable         = active_ff;
  assign dpDmOutEn         = attach_ff && !suspended_ff;
endmodule

/* inc/hrs_pkg.sv */
/*
  shared constants of the hub reset sequencer: modes, states, timing figures.
  assumes a single 40 MHz clock.
*/
package hrs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // timing figures as printed, in their own units
  localparam int unsigned RECOVER_US   = 500;
  localparam int unsigned INACTIVE_US  = 2;
  localparam int unsigned ATTACH_MS    = 100;
  localparam int unsigned EE_LOAD_MS   = 99;   // 99.5 ms: kept as tenths below
  localparam int unsigned EE_LOAD_DMS  = 995;
  localparam int unsigned REQUEST_MS   = 5;

  // cycle counts; all come out exact at 40 MHz
  localparam int unsigned RECOVER_CYC  = RECOVER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned INACTIVE_CYC = INACTIVE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ATTACH_CYC   = ATTACH_MS * (CLK_HZ / 1_000);
  localparam int unsigned EE_LOAD_CYC  = EE_LOAD_DMS * (CLK_HZ / 10_000);
  localparam int unsigned REQUEST_CYC  = REQUEST_MS * (CLK_HZ / 1_000);

  localparam int unsigned CNT_W = 24;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned PORT_N = 2;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // configuration select codes
  typedef enum logic [1:0] {
    HRS_MODE_STRAP  = 2'b00,
    HRS_MODE_EEPROM = 2'b01,
    HRS_MODE_SMBUS  = 2'b10,
    HRS_MODE_RSVD   = 2'b11
  } hrs_mode_e;

  typedef enum logic [2:0] {
    HRS_ST_RECOVER = 3'b000,
    HRS_ST_INACT   = 3'b001,
    HRS_ST_LOAD    = 3'b010,
    HRS_ST_APPLY   = 3'b011,
    HRS_ST_ATTACH  = 3'b100,
    HRS_ST_RUN     = 3'b101,
    HRS_ST_FAIL    = 3'b110
  } hrs_state_e;
endpackage

/* verification/hrs_host_model.sv */
/* upstream host and configuration loaders facing the sequencer.
   assumes the sequencer's clock; delays in cycles. */
`timescale 1ns/1ps
module hrs_host_model #(
  parameter int unsigned EE_DLY   = 8,
  parameter int unsigned SMB_DLY  = 90,
  parameter int unsigned WAIT_CYC = 10
) (
  input wire logic clk,
  input wire logic usbAttach,
  input wire logic eeLoadStart,
  input wire logic smbLoadEnable,
  input wire logic busResetReq,
  output logic     eeLoadDone = 1'b0,
  output logic     smbLoadDone = 1'b0,
  output logic     upstreamBusResetPin = 1'b0
);
  int eeCnt = 0;
  int smbCnt = 0;
  int attCnt = 0;
  always @(posedge clk) begin
    eeCnt <= eeLoadStart ? EE_DLY : (eeCnt > 0 ? eeCnt - 1 : 0);
    eeLoadDone <= eeCnt == 1;
    smbCnt <= !smbLoadEnable ? 0 : (smbCnt <= SMB_DLY ? smbCnt + 1 : smbCnt);
    smbLoadDone <= smbLoadEnable && smbCnt == SMB_DLY;
    attCnt <= usbAttach ? attCnt + 1 : 0;
    upstreamBusResetPin <= busResetReq && attCnt >= WAIT_CYC;
  end
endmodule

/* verification/hrs_seq_monitor.sv */
/* port-level timing checks of the hub reset sequencer.
   bound into hub_reset_sequencer; sees its ports only. */
`timescale 1ns/1ps
module hrs_seq_monitor
  import hrs_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = 20,
  parameter int unsigned NPORT          = 2
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [1:0]        cfgSelPin,
  input wire logic              upstreamBusResetPin,
  input wire logic              eeLoadDone,
  input wire logic              smbLoadDone,
  input wire logic              oscEnable,
  input wire logic              pllEnable,
  input wire logic              phyEnable,
  input wire logic              dpDmOutEn,
  input wire logic [NPORT-1:0]  port_power_enable,
  input wire logic [NPORT-1:0]  portEnable,
  input wire logic              operational,
  input wire logic              outputsActive,
  input wire logic              eeLoadStart,
  input wire logic              smbLoadEnable,
  input wire logic              usbAttach,
  input wire logic              configApply,
  input wire logic [NPORT-1:0]  nonRemovable,
  input wire logic [ADDR_W-1:0] deviceAddr,
  input wire logic              configured,
  input wire logic              ttFlush,
  input wire logic              downstreamReset
);
  logic [15:0] relCnt;
  logic        smbSeen;
  // cycles since reset release, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relCnt  <= 16'h0000;
      smbSeen <= 1'b0;
    end else begin
      relCnt  <= (relCnt == 16'hffff) ? relCnt : relCnt + 16'h0001;
      smbSeen <= smbSeen | smbLoadDone;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_attach; configApply ##1 usbAttach; endsequence
  property p_halt; $past(!rst_n) |-> $past(!oscEnable && !pllEnable); endproperty
  property p_quiet;
    $past(!rst_n) |-> port_power_enable == '0 && portEnable == '0 && !phyEnable && !dpDmOutEn && !usbAttach;
  endproperty
  property p_early; relCnt < RECOVER_CYCLES |-> !operational && !outputsActive; endproperty
  property p_late; relCnt == RECOVER_CYCLES + 8 |-> operational && outputsActive && phyEnable; endproperty
  property p_eeGo; $rose(operational) && cfgSelPin == HRS_MODE_EEPROM |-> ##[0:1] eeLoadStart; endproperty
  property p_eeAtt; $rose(eeLoadDone) && operational && !usbAttach |-> ##[1:3] s_attach; endproperty
  property p_smbAtt; smbLoadDone && smbLoadEnable |-> ##[1:3] s_attach; endproperty
  property p_smbWait; $rose(usbAttach) && cfgSelPin == HRS_MODE_SMBUS |-> smbSeen; endproperty
  property p_strap; operational && cfgSelPin inside {2'b01, 2'b10} |-> nonRemovable == '0; endproperty
  property p_flush; $rose(upstreamBusResetPin) && usbAttach |-> ##[1:6] ttFlush; endproperty
  property p_clear;
    ttFlush |=> deviceAddr == '0 && !configured && port_power_enable == '0 && portEnable == '0;
  endproperty
  property p_noFwd; !downstreamReset; endproperty
  property p_hold; usbAttach |=> usbAttach; endproperty
  a_halt: assert property (p_halt) else $error("clocks run in reset");
  a_quiet: assert property (p_quiet) else $error("outputs live in reset");
  a_early: assert property (p_early) else $error("operational too early");
  a_late: assert property (p_late) else $error("operational too late");
  a_eeGo: assert property (p_eeGo) else $error("eeprom read not started");
  a_eeAtt: assert property (p_eeAtt) else $error("eeprom attach missing");
  a_smbAtt: assert property (p_smbAtt) else $error("smbus attach missing");
  a_smbWait: assert property (p_smbWait) else $error("attach before code load");
  a_strap: assert property (p_strap) else $error("straps used outside strap mode");
  a_flush: assert property (p_flush) else $error("no flush on bus reset");
  a_clear: assert property (p_clear) else $error("state kept over bus reset");
  a_noFwd: assert property (p_noFwd) else $error("bus reset forwarded");
  a_hold: assert property (p_hold) else $error("attach dropped");
endmodule

bind hub_reset_sequencer hrs_seq_monitor #(.RECOVER_CYCLES(RECOVER_CYCLES), .NPORT(NPORT)) u_mon (
  .clk, .rst_n, .cfgSelPin, .upstreamBusResetPin, .eeLoadDone, .smbLoadDone, .oscEnable, .pllEnable,
  .phyEnable, .dpDmOutEn, .port_power_enable, .portEnable, .operational, .eeLoadStart, .smbLoadEnable,
  .usbAttach, .configApply, .nonRemovable, .deviceAddr, .configured, .ttFlush, .downstreamReset, .outputsActive);

/* verification/hub_reset_sequencer_bench.sv */
/* self-checking bench of the hub reset sequencer with a host model.
   reduced timing parameters; one 40 MHz clock. */
`timescale 1ns/1ps
module hub_reset_sequencer_bench;
  import hrs_pkg::*;
  localparam int unsigned RC = 20, AC = 50, EC = 60, QC = 30;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [1:0] cfgSelPin = 2'b00, strapNonRemovPin = 2'b00, portPowerReq = 2'b00;
  logic eeLoadError = 1'b0, setAddrStrobe = 1'b0, setConfigStrobe = 1'b0, suspendReq = 1'b0;
  logic requestStart = 1'b0, requestDone = 1'b0, busResetReq = 1'b0;
  logic [6:0] setAddrValue = 7'h00, deviceAddr;
  logic upstreamBusResetPin, eeLoadDone, smbLoadDone, usbAttach, eeLoadStart, smbLoadEnable;
  logic [1:0] nonRemovable, port_power_enable;
  logic configured, suspended, ttFlush, downstreamReset, requestTimeout, configFail;
  logic [15:0] attQ[$], cfgQ[$], flQ[$], tmQ[$];
  int n_fail = 0, checks_done = 0, reqCnt = 0;
  initial forever #12.5 clk = ~clk;
  hub_reset_sequencer #(.RECOVER_CYCLES(RC), .ATTACH_CYCLES(AC), .EE_LOAD_CYCLES(EC), .REQUEST_CYCLES(QC)) u_dut (
    .clk, .rst_n, .cfgSelPin, .strapNonRemovPin, .upstreamBusResetPin, .eeLoadDone, .eeLoadError, .smbLoadDone,
    .setAddrValue, .setAddrStrobe, .setConfigStrobe, .suspendReq, .requestStart, .requestDone, .portPowerReq,
    .oscEnable(), .pllEnable(), .phyEnable(), .dpDmOutEn(), .port_power_enable, .portEnable(), .outputsActive(),
    .operational(), .eeLoadStart, .smbLoadEnable, .usbAttach, .configApply(), .nonRemovable, .deviceAddr,
    .configured, .suspended, .ttFlush, .downstreamReset, .requestTimeout, .configFail);
  hrs_host_model #(.EE_DLY(8), .SMB_DLY(90), .WAIT_CYC(10)) u_host (.clk, .usbAttach, .eeLoadStart,
    .smbLoadEnable, .busResetReq, .eeLoadDone, .smbLoadDone, .upstreamBusResetPin);
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    if (attQ.size() + cfgQ.size() + flQ.size() + tmQ.size() != 0) n_fail++;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // result watcher: each appearing result takes the oldest note of its kind
  always @(posedge clk) begin
    reqCnt <= requestStart ? 0 : reqCnt + 1;
    if ($rose(usbAttach) && attQ.size() > 0) chk("attach", attQ.pop_front(), {13'h0, configFail, nonRemovable});
    if ($rose(configured) && cfgQ.size() > 0) chk("address", cfgQ.pop_front(), {9'h0, deviceAddr});
    if (ttFlush && flQ.size() > 0)
      chk("busReset", flQ.pop_front(), {4'h0, downstreamReset, configured, suspended, port_power_enable, deviceAddr});
    if ($rose(requestTimeout) && tmQ.size() > 0)
      chk("timeout", tmQ.pop_front(), {15'h0, reqCnt >= QC - 1 && reqCnt <= QC + 6});
  end
  task automatic run(input logic [1:0] m, input logic e);
    logic [1:0] s;
    logic [6:0] a;
    s = 2'($urandom);
    a = 7'($urandom_range(127, 1));
    rst_n <= 1'b0;
    cfgSelPin <= m;
    strapNonRemovPin <= s;
    eeLoadError <= e;
    busResetReq <= 1'b0;
    portPowerReq <= 2'b00;
    repeat (40) @(posedge clk);
    rst_n <= 1'b1;
    attQ.push_back({13'h0, e && m == 2'b01, (m == 2'b01 || m == 2'b10) ? 2'b00 : s});
    for (int i = 0; i < 400 && usbAttach !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    cfgQ.push_back({9'h0, a});
    tmQ.push_back(16'h0001);
    setAddrValue <= a;
    setAddrStrobe <= 1'b1;
    setConfigStrobe <= 1'b1;
    requestStart <= 1'b1;
    portPowerReq <= 2'b11;
    @(posedge clk);
    setAddrStrobe <= 1'b0;
    setConfigStrobe <= 1'b0;
    requestStart <= 1'b0;
    repeat (QC + 10) @(posedge clk);
    suspendReq <= 1'b1;
    repeat (4) @(posedge clk);
    flQ.push_back(16'h0000);
    busResetReq <= 1'b1;
    repeat (16) @(posedge clk);
    busResetReq <= 1'b0;
    suspendReq <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    void'($urandom(52958));
    repeat (16) @(posedge clk);
    for (int m = 0; m < 4; m++) run(2'(m), 1'b0);
    run(2'b01, 1'b1);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
